/* File: design/sspp_pins.sv */
// sspp_pins.sv: socket status, sense, speaker, led and power pins
// assumes: one clock, synchronous inputs, two sockets
//
// Function
// (RL1) memory mode: shared input reads as battery dead
// (RL2) io mode: shared input is active-low status change
// (RL3) ring enable bit 7 set: shared input is ring indicate for wake
// (RL4) cardbus mode: shared input is cardbus status change, may wake
// (RL5) both sense inputs together give voltage; cardbus sense pair
// (RL6) sense pull-ups follow data write bits and card-detect pull-up bits
// (RL7) audio goes to speaker only while misc control bit 4 set
// (RL8) activity led shows disk activity when led input configured
// (RL9) vendor mode bit 5: led shows socket a; b via mux control
// (RL10) system supplies 10-100 kHz reference on power clock
// (RL11) serial mode drives data and latch pins to the switch
// (RL12) parallel mode: active-low 5v and 3.3v enables, never both
// (RL13) parallel enables only in parallel mode, else serial pins
// (RL14) battery warn input may be configured as drive led input
// (RL15) serial word shifted on reference clock, then latch pulsed
// (RL16) status inputs synchronised before setting any event
`timescale 1ns/1ps
`include "sspp_params.svh"
module sspp_pins #(
	parameter int SER_W = `SSPP_SER_BITS
) (
	input  wire logic              clk_sys,
	input  wire logic              sys_rst,
	input  wire sspp_pkg::sspp_mode_t mode_a,
	input  wire sspp_pkg::sspp_mode_t mode_b,
	input  wire logic [7:0]        int_gen_ctrl,
	input  wire logic [7:0]        misc_ctrl1_a,
	input  wire logic [7:0]        misc_ctrl1_b,
	input  wire logic [7:0]        vendor_ctrl,
	input  wire logic              mux_sel_b_actv,
	input  wire logic [1:0]        led_cfg,
	input  wire logic [1:0]        battery_dead_in,
	input  wire logic [1:0]        battery_warn_audio_led_in,
	input  wire logic [1:0]        volt_sense_one,
	input  wire logic [1:0]        volt_sense_two,
	input  wire logic [1:0]        sense_data_wr,
	input  wire logic [1:0]        cd_pullup_en,
	input  wire logic              parallel_power_ctrl_mode,
	input  wire logic [1:0]        req_five,
	input  wire logic [1:0]        req_three,
	input  wire logic              ser_go,
	input  wire logic              power_serial_clock,
	output logic [1:0]             bat_dead,
	output logic [1:0]             stat_chg_evt,
	output logic [1:0]             ring_evt,
	output logic [1:0]             cb_stat_evt,
	output logic                   pme_req,
	output logic [1:0]             sense_pu_en,
	output logic [3:0]             volt_code,
	output logic                   speaker_drive_out,
	output logic                   led_out,
	output logic                   socket_a_activity,
	output logic                   socket_b_activity,
	output logic                   sock_a_five_volt_en_n,
	output logic                   sock_a_three_volt_en_n,
	output logic                   sock_b_five_volt_en_n,
	output logic                   sock_b_three_volt_en_n,
	output logic                   power_serial_dout,
	output logic                   power_serial_latch,
	output logic                   ser_busy
);
	sspp_ser_if #(.W(SER_W)) ser ();
	logic [1:0] st_s1_q, st_s2_q, st_s3_q;
	logic [1:0] ck_q;
	logic [1:0] bd_q, vo_q, vt_q;
	logic [1:0] chg_d, ring_d, cb_d;
	logic       spk_q, led_q, act_a_q, act_b_q;
	logic [3:0] pen_q;
	logic       ser_start_q;
	logic       ring_en;

	function automatic logic is_mode(input sspp_pkg::sspp_mode_t m,
		input sspp_pkg::sspp_mode_t w);
		return m == w;
	endfunction

	assign ring_en = int_gen_ctrl[`SSPP_RING_BIT];

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_s1_q <= `SSPP_SYNC_RST;
			st_s2_q <= `SSPP_SYNC_RST;
			st_s3_q <= `SSPP_SYNC_RST;
			ck_q    <= 2'h0;
		end else begin
			st_s1_q <= battery_dead_in; // RL16
			st_s2_q <= st_s1_q;
			st_s3_q <= st_s2_q;
			ck_q    <= {ck_q[0], power_serial_clock};
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_sk
			sspp_pkg::sspp_mode_t m;
			assign m = (i == 0) ? mode_a : mode_b;
			always_comb begin
				chg_d[i]  = 1'h0;
				ring_d[i] = 1'h0;
				cb_d[i]   = 1'h0;
				if (ring_en && !st_s2_q[i] && st_s3_q[i])
					ring_d[i] = 1'h1; // RL3
				else if (is_mode(m, sspp_pkg::SSPP_IO))
					chg_d[i] = !st_s2_q[i] && st_s3_q[i]; // RL2
				else if (is_mode(m, sspp_pkg::SSPP_CB))
					cb_d[i] = st_s2_q[i] && !st_s3_q[i]; // RL4
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bd_q         <= 2'h0;
			stat_chg_evt <= 2'h0;
			ring_evt     <= 2'h0;
			cb_stat_evt  <= 2'h0;
			pme_req      <= 1'h0;
		end else begin
			bd_q[0] <= is_mode(mode_a, sspp_pkg::SSPP_MEM) & st_s2_q[0]; // RL1
			bd_q[1] <= is_mode(mode_b, sspp_pkg::SSPP_MEM) & st_s2_q[1]; // RL1
			stat_chg_evt <= chg_d;
			ring_evt     <= ring_d;
			cb_stat_evt  <= cb_d;
			pme_req      <= |(ring_d | cb_d); // RL4
		end
	end
	assign bat_dead = bd_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			vo_q        <= 2'h0;
			vt_q        <= 2'h0;
			sense_pu_en <= 2'h0;
		end else begin
			vo_q        <= volt_sense_one; // RL5
			vt_q        <= volt_sense_two;
			sense_pu_en <= sense_data_wr & cd_pullup_en; // RL6
		end
	end
	assign volt_code = {vt_q[1], vo_q[1], vt_q[0], vo_q[0]}; // RL5

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			spk_q   <= 1'h0;
			led_q   <= 1'h0;
			act_a_q <= 1'h0;
			act_b_q <= 1'h0;
		end else begin
			spk_q <= (misc_ctrl1_a[`SSPP_SPKR_BIT] &
				is_mode(mode_a, sspp_pkg::SSPP_IO) &
				!battery_warn_audio_led_in[0]) |
				(misc_ctrl1_b[`SSPP_SPKR_BIT] &
				is_mode(mode_b, sspp_pkg::SSPP_IO) &
				!battery_warn_audio_led_in[1]); // RL7
			led_q <= |(led_cfg & ~battery_warn_audio_led_in); // RL8 RL14
			act_a_q <= vendor_ctrl[`SSPP_ACTV_BIT] & led_cfg[0] &
				!battery_warn_audio_led_in[0]; // RL9
			act_b_q <= mux_sel_b_actv & led_cfg[1] &
				!battery_warn_audio_led_in[1]; // RL9
		end
	end
	assign speaker_drive_out = spk_q;
	assign led_out           = vendor_ctrl[`SSPP_ACTV_BIT] ? act_a_q : led_q;
	assign socket_a_activity = act_a_q;
	assign socket_b_activity = act_b_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			pen_q <= {4{`SSPP_VCC_OFF_N}};
		else if (parallel_power_ctrl_mode) begin // RL13
			pen_q[0] <= !req_five[0]; // RL12
			pen_q[1] <= !(req_three[0] & !req_five[0]); // RL12
			pen_q[2] <= !req_five[1];
			pen_q[3] <= !(req_three[1] & !req_five[1]);
		end else
			pen_q <= {4{`SSPP_VCC_OFF_N}};
	end
	assign sock_a_five_volt_en_n  = pen_q[0];
	assign sock_a_three_volt_en_n = pen_q[1];
	assign sock_b_five_volt_en_n  = pen_q[2];
	assign sock_b_three_volt_en_n = pen_q[3];

	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			ser_start_q <= 1'h0;
		else
			ser_start_q <= ser_go & !parallel_power_ctrl_mode & !ser.busy;
	end
	assign ser.start = ser_start_q;
	assign ser.word  = SER_W'({req_three[1], req_five[1],
		req_three[0], req_five[0]});

	sspp_ser_shift #(.W(SER_W)) u_shift (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.ref_tick (ck_q[0] & !ck_q[1]), // RL10
		.s        (ser)
	);
	assign power_serial_dout  = parallel_power_ctrl_mode ? 1'h0 : ser.dout; // RL11
	assign power_serial_latch = parallel_power_ctrl_mode ? 1'h0 : ser.latch; // RL11
	assign ser_busy           = ser.busy;

	property p_excl_a;
		@(posedge clk_sys) disable iff (sys_rst)
		!(!sock_a_five_volt_en_n && !sock_a_three_volt_en_n);
	endproperty
	a_excl_a: assert property (p_excl_a) // RL12
		else $error("socket a both supplies on");
	property p_excl_b;
		@(posedge clk_sys) disable iff (sys_rst)
		!(!sock_b_five_volt_en_n && !sock_b_three_volt_en_n);
	endproperty
	a_excl_b: assert property (p_excl_b) // RL12
		else $error("socket b both supplies on");
	property p_par_off;
		@(posedge clk_sys) disable iff (sys_rst)
		!parallel_power_ctrl_mode |=> (&pen_q);
	endproperty
	a_par_off: assert property (p_par_off) // RL13
		else $error("parallel enable outside parallel mode");
	property p_ring;
		@(posedge clk_sys) disable iff (sys_rst)
		ring_evt[0] |-> $past(ring_en) && !st_s3_q[0];
	endproperty
	a_ring: assert property (p_ring) // RL3
		else $error("ring event without enable");
	property p_spk;
		@(posedge clk_sys) disable iff (sys_rst)
		speaker_drive_out |-> $past(misc_ctrl1_a[4] | misc_ctrl1_b[4]);
	endproperty
	a_spk: assert property (p_spk) // RL7
		else $error("speaker driven while disabled");
	property p_pu;
		@(posedge clk_sys) disable iff (sys_rst)
		sense_pu_en[0] |-> $past(sense_data_wr[0] & cd_pullup_en[0]);
	endproperty
	a_pu: assert property (p_pu) // RL6
		else $error("pull-up on without both controls");
	property p_bd;
		@(posedge clk_sys) disable iff (sys_rst)
		bat_dead[0] |-> $past(mode_a == sspp_pkg::SSPP_MEM);
	endproperty
	a_bd: assert property (p_bd) // RL1
		else $error("battery dead outside memory mode");
	property p_pme;
		@(posedge clk_sys) disable iff (sys_rst)
		|cb_stat_evt |-> pme_req;
	endproperty
	a_pme: assert property (p_pme) // RL4
		else $error("status change without wake");
	c_ring: cover property (@(posedge clk_sys) ring_evt[0]);
	c_latch: cover property (@(posedge clk_sys) power_serial_latch);
	c_par: cover property (@(posedge clk_sys) !sock_a_five_volt_en_n);
endmodule

/* File: design/sspp_ser_shift.sv */
// sspp_ser_shift.sv: serial shifter to the socket power switch
// assumes: ref_tick is a synchronised one-cycle tick of the power clock
`timescale 1ns/1ps
`include "sspp_params.svh"
module sspp_ser_shift #(
	parameter int W = `SSPP_SER_BITS
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	input  wire logic ref_tick,
	sspp_ser_if.shf   s
);
	sspp_pkg::sspp_ser_t st_q;
	logic [W-1:0]        sh_q;
	logic [7:0]          cnt_q;
	logic                dout_q;
	logic                latch_q;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_q    <= sspp_pkg::SSPP_IDLE;
			sh_q    <= '0;
			cnt_q   <= 8'h00;
			dout_q  <= 1'h0;
			latch_q <= 1'h0;
		end else begin
			case (st_q)
			sspp_pkg::SSPP_IDLE: begin
				latch_q <= 1'h0;
				if (s.start) begin
					sh_q  <= s.word;
					cnt_q <= 8'h00;
					st_q  <= sspp_pkg::SSPP_SHIFT;
				end
			end
			sspp_pkg::SSPP_SHIFT: if (ref_tick) begin // RL15
				dout_q <= sh_q[W-1];
				sh_q   <= {sh_q[W-2:0], 1'h0};
				cnt_q  <= cnt_q + 8'h01;
				if (cnt_q == 8'(W - 1))
					st_q <= sspp_pkg::SSPP_LATCH;
			end
			sspp_pkg::SSPP_LATCH: if (ref_tick) begin
				latch_q <= 1'h1; // RL15
				st_q    <= sspp_pkg::SSPP_IDLE;
			end
			default: st_q <= sspp_pkg::SSPP_IDLE;
			endcase
		end
	end

	assign s.busy  = (st_q != sspp_pkg::SSPP_IDLE);
	assign s.dout  = dout_q;
	assign s.latch = latch_q;

	property p_latch_one;
		@(posedge clk_sys) disable iff (sys_rst)
		$rose(latch_q) |=> !latch_q;
	endproperty
	a_latch_one: assert property (p_latch_one) // RL15
		else $error("latch held longer than one cycle");
endmodule

/* File: include/sspp_params.svh */
// sspp_params.svh: constants for the socket status and power pin block
// assumes: included by bare name from design files
`ifndef SSPP_PARAMS_SVH
`define SSPP_PARAMS_SVH
`define SSPP_RING_BIT        7
`define SSPP_SPKR_BIT        4
`define SSPP_ACTV_BIT        5
`define SSPP_SER_BITS        8
`define SSPP_SYNC_RST        2'h0
`define SSPP_VCC_OFF_N       1'h1
`endif

/* File: include/sspp_pkg.sv */
// sspp_pkg.sv: types of the socket status and power pin block
// assumes: nothing beyond the params header
package sspp_pkg;
	typedef enum logic [1:0] {
		SSPP_MEM,
		SSPP_IO,
		SSPP_CB
	} sspp_mode_t;
	typedef enum logic [1:0] {
		SSPP_IDLE,
		SSPP_SHIFT,
		SSPP_LATCH
	} sspp_ser_t;
endpackage

/* File: include/sspp_ser_if.sv */
// sspp_ser_if.sv: serial power word between top and shifter
// assumes: one clock domain
`timescale 1ns/1ps
interface sspp_ser_if #(parameter int W = 8);
	logic         start;
	logic [W-1:0] word;
	logic         busy;
	logic         dout;
	logic         latch;
	modport ctl (output start, output word, input busy, input dout,
		input latch);
	modport shf (input start, input word, output busy, output dout,
		output latch);
endinterface

/* File: tb/sspp_switch_model.sv */
// sspp_switch_model.sv: socket power switch and reference clock source
// assumes: data and latch come from clk_sys registers of the bridge
`timescale 1ns/1ps
module sspp_switch_model #(
	parameter int W = 8
) (
	input  wire logic    clk_sys,
	input  wire logic    power_serial_dout,
	input  wire logic    power_serial_latch,
	output logic         power_serial_clock,
	output logic [W-1:0] word,
	output logic         word_valid
);
	logic [W-1:0] sh_q;
	logic         lat_q;
	initial begin
		power_serial_clock = 1'b0;
		sh_q = '0;
		lat_q = 1'b0;
		word = '0;
		word_valid = 1'b0;
		forever #5000 power_serial_clock = ~power_serial_clock;
	end
	// switch takes a data bit on each rising reference edge
	always @(posedge power_serial_clock) begin
		sh_q <= {sh_q[W-2:0], power_serial_dout};
	end
	// word handed on at the latch rise
	always @(posedge clk_sys) begin
		lat_q <= power_serial_latch;
		word_valid <= power_serial_latch & ~lat_q;
		if (power_serial_latch & ~lat_q) begin
			word <= sh_q;
		end
	end
endmodule

/* File: tb/tb_top.sv */
// tb_top.sv: self-checking bench for the socket status and power pins
// assumes: switch model makes the reference clock and captures words
`timescale 1ns/1ps
module tb_top;
	logic       clk_sys, sys_rst, mux_sel_b_actv, ser_go, spk;
	logic       parallel_power_ctrl_mode, power_serial_clock, pme_req;
	logic       speaker_drive_out, led_out, socket_a_activity;
	logic       socket_b_activity, sock_a_five_volt_en_n;
	logic       sock_a_three_volt_en_n, sock_b_five_volt_en_n;
	logic       sock_b_three_volt_en_n, power_serial_dout;
	logic       power_serial_latch, ser_busy, word_valid;
	logic [7:0] int_gen_ctrl, misc_ctrl1_a, misc_ctrl1_b, vendor_ctrl;
	logic [1:0] led_cfg, battery_dead_in, battery_warn_audio_led_in;
	logic [1:0] volt_sense_one, volt_sense_two, sense_data_wr;
	logic [1:0] cd_pullup_en, req_five, req_three, bat_dead;
	logic [1:0] stat_chg_evt, ring_evt, cb_stat_evt, sense_pu_en;
	logic [3:0] volt_code, e;
	logic [7:0] word, note[$];
	logic [31:0] seed;
	int         num_errors, num_checks;
	sspp_pkg::sspp_mode_t mode_a, mode_b;

	sspp_pins #(.SER_W(8)) u_dut (.*);
	sspp_switch_model #(.W(8)) u_sw (.*);

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction
	function automatic logic [7:0] pop();
		if (note.size() == 0) begin
			return 8'hxx;
		end
		return note.pop_front();
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	// one edge on the shared status input of socket s
	task automatic ev(input int s, input sspp_pkg::sspp_mode_t md,
		input logic rg);
		logic       init;
		logic [1:0] b;
		init = (md != sspp_pkg::SSPP_CB) || rg;
		b = 2'h1 << s;
		mode_a <= sspp_pkg::SSPP_MEM;
		mode_b <= sspp_pkg::SSPP_MEM;
		int_gen_ctrl <= 8'h00;
		battery_dead_in[s] <= init;
		cyc(6);
		if (s == 0) begin
			mode_a <= md;
		end else begin
			mode_b <= md;
		end
		int_gen_ctrl <= {rg, 7'h00};
		cyc(6);
		battery_dead_in[s] <= ~init;
		if (rg) begin
			note.push_back({4'h0, b, 2'h0});
		end else if (md == sspp_pkg::SSPP_IO) begin
			note.push_back({2'h0, b, 4'h0});
		end else begin
			note.push_back({6'h0, b});
		end
		cyc(6);
	endtask

	// results taken off the note queue as they appear
	always @(posedge clk_sys) begin
		if (sys_rst === 1'b0 && {stat_chg_evt, ring_evt, cb_stat_evt} !== 6'h0)
		begin
			check({2'h0, stat_chg_evt, ring_evt, cb_stat_evt}, pop());
			check({7'h0, pme_req}, {7'h0, |{ring_evt, cb_stat_evt}});
		end
		if (sys_rst === 1'b0 && word_valid === 1'b1)
			check(word, pop());
	end

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	initial begin
		#450000;
		num_errors++;
		test_done();
	end
	initial begin
		sys_rst = 1'b1;
		{mode_a, mode_b} = {sspp_pkg::SSPP_MEM, sspp_pkg::SSPP_MEM};
		{int_gen_ctrl, misc_ctrl1_a, misc_ctrl1_b, vendor_ctrl} = '0;
		{mux_sel_b_actv, ser_go, parallel_power_ctrl_mode} = '0;
		{led_cfg, battery_dead_in, battery_warn_audio_led_in} = 6'h3f;
		{volt_sense_one, volt_sense_two, sense_data_wr} = '0;
		{cd_pullup_en, req_five, req_three} = '0;
		seed = 32'h2;
		cyc(20);
		sys_rst <= 1'b0;
		cyc(2);
		for (int s = 0; s < 2; s++) begin
			ev(s, sspp_pkg::SSPP_IO, 1'b0);
			ev(s, sspp_pkg::SSPP_CB, 1'b0);
			ev(s, sspp_pkg::SSPP_MEM, 1'b1);
		end
		$display("status event test done");
		int_gen_ctrl <= 8'h00;
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			{volt_sense_one, volt_sense_two} <= seed[3:0];
			{sense_data_wr, cd_pullup_en} <= seed[7:4];
			{vendor_ctrl[5], mux_sel_b_actv, led_cfg} <= seed[11:8];
			battery_warn_audio_led_in <= seed[13:12];
			battery_dead_in <= seed[15:14];
			cyc(4);
			e[3:2] = {volt_sense_two[1], volt_sense_one[1]};
			e[1:0] = {volt_sense_two[0], volt_sense_one[0]};
			check({6'h0, sense_pu_en}, {6'h0, sense_data_wr & cd_pullup_en});
			check({4'h0, volt_code}, {4'h0, e});
			check({6'h0, bat_dead}, {6'h0, battery_dead_in});
			e[0] = |(led_cfg & ~battery_warn_audio_led_in);
			e[1] = vendor_ctrl[5] & led_cfg[0] &
				~battery_warn_audio_led_in[0];
			e[2] = mux_sel_b_actv & led_cfg[1] &
				~battery_warn_audio_led_in[1];
			e[3] = vendor_ctrl[5] ? e[1] : e[0];
			check({7'h0, led_out}, {7'h0, e[3]});
			check({6'h0, socket_a_activity, socket_b_activity},
				{6'h0, e[1], e[2]});
		end
		$display("sense test done");
		mode_a <= sspp_pkg::SSPP_IO;
		led_cfg <= 2'h0;
		for (int en = 0; en < 2; en++) begin
			misc_ctrl1_a <= {3'h0, en[0], 4'h0};
			battery_warn_audio_led_in[0] <= 1'b0;
			cyc(4);
			spk = speaker_drive_out;
			battery_warn_audio_led_in[0] <= 1'b1;
			cyc(4);
			check({7'h0, spk !== speaker_drive_out}, {7'h0, en[0]});
		end
		$display("speaker test done");
		for (int p = 1; p >= 0; p--) begin
			parallel_power_ctrl_mode <= p[0];
			for (int i = 0; i < 3; i++) begin
				seed = xs(seed);
				req_five <= seed[1:0];
				req_three <= seed[3:2] & (p ? 2'h3 : ~seed[1:0]);
				ser_go <= 1'b1;
				cyc(1);
				ser_go <= 1'b0;
				cyc(4);
				e[3:2] = {req_five[0], req_three[0] & ~req_five[0]};
				e[1:0] = {req_five[1], req_three[1] & ~req_five[1]};
				e = p ? ~e : 4'hf;
				check({4'h0, sock_a_five_volt_en_n, sock_a_three_volt_en_n,
					sock_b_five_volt_en_n, sock_b_three_volt_en_n}, {4'h0, e});
				if (p == 0) begin
					note.push_back({4'h0, req_three[1], req_five[1],
						req_three[0], req_five[0]});
					for (int k = 0; k < 30000 && ser_busy !== 1'b0; k++) cyc(1);
					cyc(4);
				end else begin
					check({5'h0, power_serial_dout, power_serial_latch, ser_busy},
						8'h00);
				end
			end
		end
		check({7'h0, note.size() == 0}, 8'h01);
		$display("power test done");
		test_done();
	end
endmodule
